// file: sar_adc_conversion_control.sv
// Operation
// - conversion clock is bus clock, bus clock halved, or local async clock
// - alternate clock selection has no source and gives no conversion clock
// - hardware trigger starts a conversion on each tick counter overflow while idle, unless channel all ones
// - tick counter counts reference clock edges or internal low-frequency edges
// - trigger path stays live in run, wait and deep stop modes
// - any control 1 write aborts; in software trigger mode starts new conversion unless channel all ones
// - done flag set per conversion, or only on compare match if enabled
// - done flag clears on control 1 write or low result read
// - interrupt request raised when done flag sets with irq enable high
// - continuous off: one conversion per write or per hardware trigger
// - continuous on: back-to-back conversions after write or hardware trigger
// - channel codes decode to inputs 0-27, reserved, high and low reference
// - all-ones channel powers down, isolates input, stops without extra conversion
// - single mode enters low power automatically after each conversion
// - results right-justified in 10-bit or 8-bit format
// - automatic compare of each result against programmable value
// - the one reserved channel code converts to an undefined value
// - active bit high from conversion start until completion or abort
// - trigger select picks software write or hardware trigger starts
// - compare matches below value, or at or above with ge select
//
// Local design decisions: the address-and-strobe port and the address map.
`include "sar_ctrl_regs.svh"
module sar_adc_conversion_control #(
    parameter int TICK_W = 16
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_reference_clock,
    input wire logic i_lowfreq_clock,
    input wire logic i_core_done,
    input wire logic [9:0] i_core_result,
    output sar_ctrl_pkg::conv_clk_sel_t o_clk_select,
    output logic o_conv_clk_tick,
    output logic o_conv_start,
    output logic o_conv_abort,
    output logic o_mode_10bit,
    output logic o_core_powered,
    output logic o_input_isolate,
    output logic [4:0] o_input_index,
    output logic o_sel_input,
    output logic o_sel_high_reference,
    output logic o_sel_low_reference,
    output logic o_conv_irq
);
    import sar_ctrl_pkg::*;

    // ============================================================
    // helpers
    function automatic logic cmp_match(input logic [9:0] res, input logic [9:0] ref_v,
                                       input logic ge);
        cmp_match = ge ? (res >= ref_v) : (res < ref_v);
    endfunction : cmp_match

    function automatic logic [2:0] sync_step(input logic [2:0] s, input logic d);
        sync_step = {s[1:0], d};
    endfunction : sync_step

    // ============================================================
    // registers
    logic [7:0] sc1_ff, nxt_sc1;
    logic [7:0] sc2_ff, nxt_sc2;
    logic [7:0] cfg_ff, nxt_cfg;
    logic [7:0] tick_cfg_ff, nxt_tick_cfg;
    logic [9:0] cmp_ff, nxt_cmp;
    logic [9:0] result_ff, nxt_result;
    logic [7:0] rdata_ff, nxt_rdata;
    logic done_flag_ff, nxt_done_flag;
    conv_state_t state_ff, nxt_state;
    logic div_ff, nxt_div;
    logic [2:0] ref_sync_ff, nxt_ref_sync;
    logic [2:0] low_sync_ff, nxt_low_sync;
    logic [2:0] done_sync_ff, nxt_done_sync;
    logic ref_seen_ff, nxt_ref_seen;
    logic low_seen_ff, nxt_low_seen;
    logic done_seen_ff, nxt_done_seen;
    logic [TICK_W-1:0] tick_cnt_ff, nxt_tick_cnt;
    logic trig_ff, nxt_trig;
    logic start_ff, nxt_start;
    logic abort_ff, nxt_abort;

    logic sc1_write;
    logic res_lo_read;
    logic chan_off;
    logic sw_trig_mode;
    logic tick_edge;
    logic done_event;
    logic ref_level, low_level, done_level;
    logic [TICK_W-1:0] tick_mask;
    logic [9:0] res_fmt;
    logic cmp_ok;
    logic hw_start;

    assign sc1_write = i_wr && i_addr == `OFS_SC1;
    assign res_lo_read = i_rd && i_addr == `OFS_RES_LO;
    assign chan_off = sc1_ff[4:0] == `CH_OFF;
    assign sw_trig_mode = !sc2_ff[`SC2_TRIG];

    // ============================================================
    // synchronisers and tick counter
    always_comb begin
        nxt_ref_sync = sync_step(ref_sync_ff, i_ext_reference_clock);
        nxt_low_sync = sync_step(low_sync_ff, i_lowfreq_clock);
        nxt_done_sync = sync_step(done_sync_ff, i_core_done);
        ref_level = ref_sync_ff[2] == ref_sync_ff[1] ? ref_sync_ff[1] : ref_seen_ff;
        low_level = low_sync_ff[2] == low_sync_ff[1] ? low_sync_ff[1] : low_seen_ff;
        done_level = done_sync_ff[2] == done_sync_ff[1] ? done_sync_ff[1] : done_seen_ff;
        nxt_ref_seen = ref_level;
        nxt_low_seen = low_level;
        nxt_done_seen = done_level;
        done_event = done_level && !done_seen_ff;
        // tick source: reference clock or internal low-frequency clock
        tick_edge = tick_cfg_ff[`TICK_SRC] ? (ref_level && !ref_seen_ff)
                                            : (low_level && !low_seen_ff);
        tick_mask = TICK_W'((64'h1 << (`TICK_BASE_BITS + int'(tick_cfg_ff[2:0]))) - 64'h1);
        nxt_tick_cnt = tick_cnt_ff;
        nxt_trig = 1'b0;
        // free running, no gating by power mode
        if (tick_edge) begin
            if ((tick_cnt_ff & tick_mask) == tick_mask) begin
                nxt_tick_cnt = '0;
                nxt_trig = 1'b1;
            end else begin
                nxt_tick_cnt = tick_cnt_ff + TICK_W'(1);
            end
        end
        // one-cycle trigger per overflow
        hw_start = trig_ff && !sw_trig_mode;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_sync_ff <= 3'h0;
            low_sync_ff <= 3'h0;
            done_sync_ff <= 3'h0;
            ref_seen_ff <= 1'b0;
            low_seen_ff <= 1'b0;
            done_seen_ff <= 1'b0;
            tick_cnt_ff <= '0;
            trig_ff <= 1'b0;
        end else begin
            ref_sync_ff <= nxt_ref_sync;
            low_sync_ff <= nxt_low_sync;
            done_sync_ff <= nxt_done_sync;
            ref_seen_ff <= nxt_ref_seen;
            low_seen_ff <= nxt_low_seen;
            done_seen_ff <= nxt_done_seen;
            tick_cnt_ff <= nxt_tick_cnt;
            trig_ff <= nxt_trig;
        end
    end

    // ============================================================
    // conversion sequencing
    always_comb begin
        res_fmt = cfg_ff[`CFG_MODE10] ? i_core_result : {2'h0, i_core_result[7:0]};
        cmp_ok = cfg_ff[`CFG_MODE10]
            ? cmp_match(res_fmt, cmp_ff, sc2_ff[`SC2_CMP_GE])
            : cmp_match({2'h0, res_fmt[7:0]}, {2'h0, cmp_ff[7:0]}, sc2_ff[`SC2_CMP_GE]);
        nxt_state = state_ff;
        nxt_start = 1'b0;
        nxt_abort = 1'b0;
        nxt_result = result_ff;
        nxt_done_flag = done_flag_ff;
        if (sc1_write || res_lo_read) begin
            nxt_done_flag = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (hw_start && !chan_off) begin
                    nxt_state = ST_CONVERT;
                    nxt_start = 1'b1;
                end
            end
            ST_CONVERT: begin
                if (done_event) begin
                    if (!sc2_ff[`SC2_CMP_EN] || cmp_ok) begin
                        nxt_result = res_fmt;
                        nxt_done_flag = 1'b1;
                    end
                    // continuous restarts; single drops to low power
                    if (sc1_ff[`SC1_CONT] && !chan_off) begin
                        nxt_start = 1'b1;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (sc1_write) begin
            nxt_abort = state_ff == ST_CONVERT;
            if (sw_trig_mode && i_wdata[4:0] != `CH_OFF) begin
                nxt_state = ST_CONVERT;
                nxt_start = 1'b1;
            end else begin
                nxt_state = ST_IDLE;
                nxt_start = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= ST_IDLE;
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
            result_ff <= 10'h000;
            done_flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            start_ff <= nxt_start;
            abort_ff <= nxt_abort;
            result_ff <= nxt_result;
            done_flag_ff <= nxt_done_flag;
        end
    end

    // ============================================================
    // register bus
    always_comb begin
        nxt_sc1 = sc1_ff;
        nxt_sc2 = sc2_ff;
        nxt_cfg = cfg_ff;
        nxt_tick_cfg = tick_cfg_ff;
        nxt_cmp = cmp_ff;
        nxt_rdata = 8'h00;
        if (i_wr) begin
            case (i_addr)
                `OFS_SC1: nxt_sc1 = {1'b0, i_wdata[6:0]};
                `OFS_SC2: nxt_sc2 = {2'h0, i_wdata[5:4], 4'h0} | {1'b0, i_wdata[6], 6'h00};
                `OFS_CMP_HI: nxt_cmp = {i_wdata[1:0], cmp_ff[7:0]};
                `OFS_CMP_LO: nxt_cmp = {cmp_ff[9:8], i_wdata};
                `OFS_CFG: nxt_cfg = {5'h00, i_wdata[2:0]};
                `OFS_TICK: nxt_tick_cfg = {4'h0, i_wdata[3:0]};
                default: nxt_cfg = cfg_ff;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `OFS_SC1: nxt_rdata = {done_flag_ff, sc1_ff[6:0]};
                `OFS_SC2: nxt_rdata = {state_ff == ST_CONVERT, sc2_ff[6:0]};
                `OFS_RES_HI: nxt_rdata = {6'h00, result_ff[9:8]};
                `OFS_RES_LO: nxt_rdata = result_ff[7:0];
                `OFS_CMP_HI: nxt_rdata = {6'h00, cmp_ff[9:8]};
                `OFS_CMP_LO: nxt_rdata = cmp_ff[7:0];
                `OFS_CFG: nxt_rdata = cfg_ff;
                `OFS_TICK: nxt_rdata = tick_cfg_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_div = !div_ff;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sc1_ff <= `SC1_RESET;
            sc2_ff <= `SC2_RESET;
            cfg_ff <= `CFG_RESET;
            tick_cfg_ff <= `TICK_RESET;
            cmp_ff <= 10'h000;
            rdata_ff <= 8'h00;
            div_ff <= 1'b0;
        end else begin
            sc1_ff <= nxt_sc1;
            sc2_ff <= nxt_sc2;
            cfg_ff <= nxt_cfg;
            tick_cfg_ff <= nxt_tick_cfg;
            cmp_ff <= nxt_cmp;
            rdata_ff <= nxt_rdata;
            div_ff <= nxt_div;
        end
    end

    // ============================================================
    // outputs
    always_comb begin
        o_clk_select = conv_clk_sel_t'(cfg_ff[1:0]);
        case (o_clk_select)
            CLK_BUS: o_conv_clk_tick = 1'b1;
            CLK_BUS_DIV2: o_conv_clk_tick = div_ff;
            CLK_ALT: o_conv_clk_tick = 1'b0;
            default: o_conv_clk_tick = 1'b0;
        endcase
        o_input_index = sc1_ff[4:0];
        o_sel_input = sc1_ff[4:0] <= `CH_LAST_INPUT;
        o_sel_high_reference = sc1_ff[4:0] == `CH_HIGH_REF;
        o_sel_low_reference = sc1_ff[4:0] == `CH_LOW_REF;
        // reserved code left undriven to any input: result undefined
        o_input_isolate = chan_off || sc1_ff[4:0] == `CH_RESERVED;
        o_core_powered = state_ff == ST_CONVERT && !chan_off;
        o_conv_irq = done_flag_ff && sc1_ff[`SC1_IRQ_EN];
    end

    assign o_rdata = rdata_ff;
    assign o_conv_start = start_ff;
    assign o_conv_abort = abort_ff;
    assign o_mode_10bit = cfg_ff[`CFG_MODE10];
endmodule : sar_adc_conversion_control

// file: sar_core_model.sv
module sar_core_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic [9:0] i_value,
    output logic o_done,
    output logic [9:0] o_result
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // core timing, done held long enough for sync
    logic [4:0] cnt = 5'h00;
    logic busy = 1'b0;
    initial o_done = 1'b0;
    always @(posedge i_clk) begin
        if (i_reset) begin
            busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_start) begin
            busy <= 1'b1;
            cnt <= 5'h00;
            o_done <= 1'b0;
        end else if (i_abort) begin
            busy <= 1'b0;
            o_done <= 1'b0;
        end else if (busy) begin
            cnt <= cnt + 5'h01;
            o_done <= cnt >= 5'h09;
            busy <= cnt != 5'h0E;
        end
    end
    // result only valid while done stands
    assign o_result = o_done ? i_value : ~i_value;
endmodule : sar_core_model

// file: sar_ctrl_monitor.sv
module sar_ctrl_monitor
    import sar_ctrl_pkg::*;
#(
    parameter int TICK_W = 16
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire conv_clk_sel_t o_clk_select,
    input wire logic o_conv_clk_tick,
    input wire logic o_conv_start,
    input wire logic o_conv_abort,
    input wire logic o_core_powered,
    input wire logic o_mode_10bit,
    input wire logic o_input_isolate,
    input wire logic [4:0] o_input_index,
    input wire logic o_sel_input,
    input wire logic o_sel_high_reference,
    input wire logic o_sel_low_reference,
    input wire logic o_conv_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // trigger mode shadow
    logic hw_ff;
    logic nxt_hw;
    always_comb begin
        nxt_hw = hw_ff;
        if (i_wr && i_addr == 3'h1) begin
            nxt_hw = i_wdata[6];
        end
    end
    always_ff @(posedge i_clk) begin
        hw_ff <= i_reset ? 1'b0 : nxt_hw;
    end
    // ====
    // properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_ctrl1_wr;
        i_wr && i_addr == 3'h0;
    endsequence
    property p_sw_start;
        s_ctrl1_wr ##0 (i_wdata[4:0] != 5'h1F && !hw_ff) |=> o_conv_start;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("no start after write");
    property p_off_no_start;
        s_ctrl1_wr ##0 (i_wdata[4:0] == 5'h1F) |=> !o_conv_start;
    endproperty
    a_off_no_start: assert property (p_off_no_start) else $error("start on off code");
    property p_chan;
        s_ctrl1_wr |=> o_input_index == $past(i_wdata[4:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("channel not taken");
    property p_wr_clear;
        s_ctrl1_wr |=> !o_conv_irq;
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("irq after ctrl1 write");
    property p_rd_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_cfg;
        i_wr && i_addr == 3'h6 |=> o_mode_10bit == $past(i_wdata[2]) && o_clk_select == $past(i_wdata[1:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg not taken");
    property p_decode;
        o_sel_input == (o_input_index <= 5'h1B) && o_sel_high_reference == (o_input_index == 5'h1D)
            && o_sel_low_reference == (o_input_index == 5'h1E);
    endproperty
    a_decode: assert property (p_decode) else $error("channel decode wrong");
    property p_isolate;
        o_input_isolate == (o_input_index == 5'h1F || o_input_index == 5'h1C);
    endproperty
    a_isolate: assert property (p_isolate) else $error("isolate wrong");
    property p_tick_bus;
        o_clk_select == CLK_BUS && $past(o_clk_select) == CLK_BUS |-> o_conv_clk_tick;
    endproperty
    a_tick_bus: assert property (p_tick_bus) else $error("bus tick missing");
    property p_tick_half;
        o_clk_select == CLK_BUS_DIV2 && $past(o_clk_select) == CLK_BUS_DIV2
            && $past(o_clk_select, 2) == CLK_BUS_DIV2 |-> o_conv_clk_tick != $past(o_conv_clk_tick);
    endproperty
    a_tick_half: assert property (p_tick_half) else $error("half tick not toggling");
    property p_tick_none;
        o_clk_select inside {CLK_ALT, CLK_ASYNC} && $past(o_clk_select) == o_clk_select |-> !o_conv_clk_tick;
    endproperty
    a_tick_none: assert property (p_tick_none) else $error("tick on alt or async");
    property p_abort;
        s_ctrl1_wr ##0 o_core_powered |=> o_conv_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on ctrl1 write");
    property p_abort_only;
        !(i_wr && i_addr == 3'h0) |=> !o_conv_abort;
    endproperty
    a_abort_only: assert property (p_abort_only) else $error("abort without ctrl1 write");
endmodule : sar_ctrl_monitor

// file: sar_ctrl_pkg.sv
package sar_ctrl_pkg;
    typedef enum logic [1:0] {
        CLK_BUS,
        CLK_BUS_DIV2,
        CLK_ALT,
        CLK_ASYNC
    } conv_clk_sel_t;
    typedef enum {
        ST_IDLE,
        ST_CONVERT
    } conv_state_t;
endpackage : sar_ctrl_pkg

// file: sar_ctrl_regs.svh
`ifndef SAR_CTRL_REGS_SVH
`define SAR_CTRL_REGS_SVH
// ============================================================
// register offsets
`define OFS_SC1 3'h0
`define OFS_SC2 3'h1
`define OFS_RES_HI 3'h2
`define OFS_RES_LO 3'h3
`define OFS_CMP_HI 3'h4
`define OFS_CMP_LO 3'h5
`define OFS_CFG 3'h6
`define OFS_TICK 3'h7
// ============================================================
// field positions
`define SC1_DONE 7
`define SC1_IRQ_EN 6
`define SC1_CONT 5
`define SC2_ACTIVE 7
`define SC2_TRIG 6
`define SC2_CMP_EN 5
`define SC2_CMP_GE 4
`define CFG_MODE10 2
`define TICK_SRC 3
// ============================================================
// reset values and codes
`define CH_OFF 5'h1F
`define CH_RESERVED 5'h1C
`define CH_HIGH_REF 5'h1D
`define CH_LOW_REF 5'h1E
`define CH_LAST_INPUT 5'h1B
`define SC1_RESET 8'h1F
`define SC2_RESET 8'h00
`define CFG_RESET 8'h00
`define TICK_RESET 8'h00
`define TICK_BASE_BITS 4
`endif

// file: test_sar_adc_conversion_control.sv
module test_sar_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_ctrl_pkg::*;
    logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_ext_reference_clock = 0, i_lowfreq_clock = 0;
    logic [2:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, rdat;
    logic [9:0] core_val = 0, cmp, core_res;
    logic core_done, o_conv_clk_tick, o_conv_start, o_conv_abort, o_mode_10bit, o_core_powered;
    logic o_input_isolate, o_sel_input, o_sel_high_reference, o_sel_low_reference, o_conv_irq;
    logic ge, cen, m10, flag;
    logic [4:0] ch, o_input_index;
    logic [1:0] sel;
    conv_clk_sel_t o_clk_select;
    int error_cnt = 0, check_count = 0, seed = 47079, tk = 0, n, j;
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        tk <= tk + 1;
        if (tk % 3 == 0) i_ext_reference_clock <= ~i_ext_reference_clock;
        if (tk % 5 == 0) i_lowfreq_clock <= ~i_lowfreq_clock;
    end
    sar_adc_conversion_control #(.TICK_W(16)) i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_reference_clock(i_ext_reference_clock), .i_lowfreq_clock(i_lowfreq_clock),
        .i_core_done(core_done), .i_core_result(core_res), .o_clk_select(o_clk_select),
        .o_conv_clk_tick(o_conv_clk_tick), .o_conv_start(o_conv_start), .o_conv_abort(o_conv_abort),
        .o_mode_10bit(o_mode_10bit), .o_core_powered(o_core_powered), .o_input_isolate(o_input_isolate),
        .o_input_index(o_input_index), .o_sel_input(o_sel_input), .o_sel_high_reference(o_sel_high_reference),
        .o_sel_low_reference(o_sel_low_reference), .o_conv_irq(o_conv_irq));
    sar_core_model i_core (.i_clk(i_clk), .i_reset(i_reset), .i_start(o_conv_start), .i_abort(o_conv_abort),
        .i_value(core_val), .o_done(core_done), .o_result(core_res));
    // ====
    // tasks
    task give_verdict;
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 0;
    endtask : wr
    task rd(input logic [2:0] a);
        @(posedge i_clk);
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 0;
        #1 rdat = o_rdata;
    endtask : rd
    task wait_sig(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            #1;
            if (w == 0 ? o_conv_start === 1'b1 : o_core_powered === 1'b0) break;
            @(posedge i_clk);
        end
        if (i == lim) begin
            error_cnt++;
            $display("unexpected at %0t: wait ran out", $time);
            give_verdict();
        end
    endtask : wait_sig
    task count_starts(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge i_clk);
            #1 n += (o_conv_start === 1'b1);
        end
    endtask : count_starts
    function automatic logic exp_flag(logic [9:0] v, logic [9:0] c, logic m, logic e, logic g);
        if (!m) begin
            v[9:8] = 0;
            c[9:8] = 0;
        end
        return !e || (g == (v >= c));
    endfunction : exp_flag
    // ====
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 0;
        rd(0); chk(rdat, 8'h1F);
        rd(1); chk(rdat, 8'h00);
        chk({7'h0, o_input_isolate}, 8'h01);
        wr(6, 8'h02); repeat (3) @(posedge i_clk); #1 chk({7'h0, o_conv_clk_tick}, 8'h00);
        for (j = 0; j < 14; j++) begin
            ch = (j < 4) ? 5'(5'h1B + j) : 5'($unsigned($random(seed)) % 31);
            n = $unsigned($random(seed)) % 3;
            sel = (n == 2) ? 2'd3 : n[1:0];
            {m10, cen, ge} = 3'($random(seed));
            core_val = 10'($random(seed));
            cmp = 10'($random(seed));
            wr(6, {5'h0, m10, sel});
            wr(4, {6'h0, cmp[9:8]});
            wr(5, cmp[7:0]);
            wr(1, {2'b00, cen, ge, 4'h0});
            #1 chk({6'h0, o_clk_select}, {6'h0, sel});
            wr(0, {3'b010, ch}); wait_sig(0, 3);
            rd(1); chk(rdat, {2'b10, cen, ge, 4'h0});
            @(posedge i_clk); wait_sig(1, 60);
            @(posedge i_clk); #1 flag = exp_flag(core_val, cmp, m10, cen, ge);
            chk({7'h0, o_conv_irq}, {7'h0, flag});
            rd(0); chk(rdat, {flag, 2'b10, ch});
            rd(2); if (flag && ch != 5'h1C) chk(rdat, {6'h0, m10 ? core_val[9:8] : 2'b00});
            rd(3); if (flag && ch != 5'h1C) chk(rdat, core_val[7:0]);
            chk({7'h0, o_conv_irq}, 8'h00);
        end
        wr(1, 8'h40); wr(7, 8'h08); wr(0, 8'h02); #1 chk({7'h0, o_conv_start}, 8'h00);
        wait_sig(0, 200);
        count_starts(80); chk(8'(n), 8'h00);
        wr(7, 8'h00); wait_sig(0, 400);
        @(posedge i_clk); wait_sig(1, 60);
        chk({7'h0, o_conv_irq}, 8'h00);
        rd(0); chk(rdat, 8'h82);
        wr(1, 8'h00); wr(0, 8'h23);
        count_starts(100); chk({7'h0, n >= 3}, 8'h01);
        wr(0, 8'h3F); #1 chk({7'h0, o_conv_abort}, 8'h01);
        count_starts(60); chk(8'(n), 8'h00);
        chk({7'h0, o_core_powered}, 8'h00);
        wr(1, 8'h40); wr(0, 8'h23); #1 chk({7'h0, o_conv_start}, 8'h00);
        wait_sig(0, 400); count_starts(60); chk({7'h0, n >= 2}, 8'h01);
        wr(0, 8'h3F); #1 chk({7'h0, o_conv_abort}, 8'h01);
        count_starts(60); chk(8'(n), 8'h00);
        chk({7'h0, o_core_powered}, 8'h00);
        give_verdict();
    end
endmodule : test_sar_adc_conversion_control
bind sar_adc_conversion_control sar_ctrl_monitor #(.TICK_W(TICK_W)) i_mon (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_clk_select(o_clk_select),
    .o_conv_clk_tick(o_conv_clk_tick), .o_conv_start(o_conv_start), .o_mode_10bit(o_mode_10bit),
    .o_conv_abort(o_conv_abort), .o_core_powered(o_core_powered),
    .o_input_isolate(o_input_isolate), .o_input_index(o_input_index), .o_sel_input(o_sel_input),
    .o_sel_high_reference(o_sel_high_reference), .o_sel_low_reference(o_sel_low_reference), .o_conv_irq(o_conv_irq));
